/* File: vfd_params.svh */
// Constants for the display module host port.
// Assumes inclusion by bare name from the package and the port modules.
`ifndef VFD_PARAMS_SVH
`define VFD_PARAMS_SVH

// Width of the synchronised pin vector
`define VFD_SYNC_W        15
// Reset value of the synchronised pins, every line idle high
`define VFD_SYNC_RST      15'h7FFF

// Bit positions in the synchronised pin vector
`define VFD_PIN_DATA_LSB  0
`define VFD_PIN_DATA_MSB  7
`define VFD_PIN_CS_B      8
`define VFD_PIN_WR_B      9
`define VFD_PIN_RD_B      10
`define VFD_PIN_CMD_SEL   11
`define VFD_PIN_STRAP     12
`define VFD_PIN_SCLK      13
`define VFD_PIN_SI        14

// Cycles between frame pulses
`define VFD_FRAME_CYCLES  16'h0100
// Clock edges after reset release before the strap is caught;
// the synchroniser needs four edges to flush its idle-high reset value
`define VFD_STRAP_WAIT    3'h4
// Last bit index of a serial byte
`define VFD_SER_LAST_BIT  3'h7

`endif

/* File: vfd_pkg.sv */
// Types shared by the display module host port.
// Assumes vfd_params.svh in the include path.
`include "vfd_params.svh"

package vfd_pkg;

  typedef enum logic {
    MODE_PARALLEL = 1'b0,
    MODE_SERIAL   = 1'b1
  } port_mode_t;

  typedef struct packed {
    logic [`VFD_SYNC_W-1:0] s1;
    logic [`VFD_SYNC_W-1:0] s2;
    logic [`VFD_SYNC_W-1:0] s3;
    logic [`VFD_SYNC_W-1:0] clean;
  } sync_state_t;

  typedef struct packed {
    logic       strap_done;
    logic [2:0] strap_cnt;
    port_mode_t mode;
    logic       wr_prev;
    logic       rd_prev;
    logic       sclk_prev;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic       so;
    logic [7:0] cmd_byte;
    logic       cmd_valid;
    logic [7:0] data_byte;
    logic       data_valid;
    logic       rd_req;
    logic [7:0] bus_out;
    logic       bus_oe;
    logic [15:0] frame_cnt;
    logic       frame_pulse;
  } port_state_t;

endpackage

/* File: vfd_pin_sync.sv */
// Three-stage synchroniser with agreement filter for the port pins.
// Assumes asynchronous pins and a single clock domain.
`timescale 1ns/1ps
`include "vfd_params.svh"

module vfd_pin_sync (
  input  logic                   clock,
  input  logic                   rst_b,
  input  logic [`VFD_SYNC_W-1:0] pins,
  output logic [`VFD_SYNC_W-1:0] clean
);

  vfd_pkg::sync_state_t st_reg;
  vfd_pkg::sync_state_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < `VFD_SYNC_W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.clean[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= {4{`VFD_SYNC_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign clean = st_reg.clean;

endmodule

/* File: vfd_host_port.sv */
// Host access port of a dot graphic fluorescent display module.
// Assumes pins arrive asynchronously and the core answers reads on rd_data.
// Functional notes
// (RULE1) Chip select low, read high, select high: write strobe rise latches a command.
// (RULE2) Chip select low, read high, select low: write strobe rise latches a data byte.
// (RULE3) Chip select low, write high, read low, select low: device drives read data.
// (RULE4) The host marks commands with the select line high and data with it low.
// (RULE5) With the select line low the eight-bit bus carries data both ways.
// (RULE6) Exactly one pulse on the frame output per refreshed display frame.
// (RULE7) Strap open selects the parallel port, strap grounded selects serial.
// (RULE8) Serial mode moves bytes on host clock, serial input and serial output.
// (RULE9) In serial mode the parallel strobes govern nothing.
// (RULE10) The host follows a parameterised command with its setting data bytes.
// (RULE11) Chip select high: strobes ignored and the bus left undriven.
`timescale 1ns/1ps
`include "vfd_params.svh"

module vfd_host_port #(
  parameter logic [15:0] FRAME_CYCLES = `VFD_FRAME_CYCLES
) (
  input  logic       clock,
  input  logic       rst_b,
  input  logic       cs_b,
  input  logic       wr_b,
  input  logic       rd_b,
  input  logic       cmd_sel,
  input  logic       port_strap,
  input  logic       sclk,
  input  logic       si,
  input  logic [7:0] host_data_bus_in,
  input  logic [7:0] rd_data,
  output logic [7:0] host_data_bus_out,
  output logic       host_data_bus_oe,
  output logic       so,
  output logic       frame_pulse,
  output logic [7:0] cmd_byte,
  output logic       cmd_valid,
  output logic [7:0] data_byte,
  output logic       data_valid,
  output logic       rd_req
);

  logic [`VFD_SYNC_W-1:0] sy;
  logic                   sy_cs_b;
  logic                   sy_wr_b;
  logic                   sy_rd_b;
  logic                   sy_cmd;
  logic                   sy_strap;
  logic                   sy_sclk;
  logic                   sy_si;
  logic [7:0]             sy_data;
  logic                   par_on;
  logic                   ser_on;
  logic                   read_cond;
  vfd_pkg::port_state_t   st_reg;
  vfd_pkg::port_state_t   st_next;

  vfd_pin_sync u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .pins  ({si, sclk, port_strap, cmd_sel, rd_b, wr_b, cs_b, host_data_bus_in}),
    .clean (sy)
  );

  assign sy_data  = sy[`VFD_PIN_DATA_MSB:`VFD_PIN_DATA_LSB];
  assign sy_cs_b  = sy[`VFD_PIN_CS_B];
  assign sy_wr_b  = sy[`VFD_PIN_WR_B];
  assign sy_rd_b  = sy[`VFD_PIN_RD_B];
  assign sy_cmd   = sy[`VFD_PIN_CMD_SEL];
  assign sy_strap = sy[`VFD_PIN_STRAP];
  assign sy_sclk  = sy[`VFD_PIN_SCLK];
  assign sy_si    = sy[`VFD_PIN_SI];

  // Port enables after the strap is caught
  assign par_on    = st_reg.strap_done && (st_reg.mode == vfd_pkg::MODE_PARALLEL) && !sy_cs_b;
  assign ser_on    = st_reg.strap_done && (st_reg.mode == vfd_pkg::MODE_SERIAL) && !sy_cs_b;
  assign read_cond = par_on && sy_wr_b && !sy_rd_b && !sy_cmd;

  always_comb begin
    st_next             = st_reg;
    st_next.cmd_valid   = 1'b0;
    st_next.data_valid  = 1'b0;
    st_next.rd_req      = 1'b0;
    st_next.frame_pulse = 1'b0;
    st_next.wr_prev     = sy_wr_b;
    st_next.rd_prev     = sy_rd_b;
    st_next.sclk_prev   = sy_sclk;

    // Strap caught once after reset release
    if (!st_reg.strap_done) begin
      if (st_reg.strap_cnt == `VFD_STRAP_WAIT) begin
        st_next.strap_done = 1'b1;
        st_next.mode = sy_strap ? vfd_pkg::MODE_PARALLEL : vfd_pkg::MODE_SERIAL; // see RULE7
      end else begin
        st_next.strap_cnt = st_reg.strap_cnt + 3'h1;
      end
    end

    // Frame timer
    if (st_reg.frame_cnt == FRAME_CYCLES - 16'h0001) begin
      st_next.frame_cnt   = 16'h0000;
      st_next.frame_pulse = 1'b1; // see RULE6
    end else begin
      st_next.frame_cnt = st_reg.frame_cnt + 16'h0001;
    end

    // Parallel strobes, only while selected; see RULE11 and RULE9
    if (par_on && !st_reg.wr_prev && sy_wr_b && sy_rd_b) begin
      if (sy_cmd) begin
        st_next.cmd_byte  = sy_data; // see RULE1
        st_next.cmd_valid = 1'b1;
      end else begin
        st_next.data_byte  = sy_data; // see RULE2
        st_next.data_valid = 1'b1;
      end
    end
    if (read_cond && st_reg.rd_prev) begin
      st_next.rd_req = 1'b1;
    end

    // Bus drive during a data read; see RULE3 and RULE5
    st_next.bus_oe = read_cond;
    if (read_cond) begin
      st_next.bus_out = rd_data;
    end

    // Serial shifter; see RULE8
    if (ser_on) begin
      if (!st_reg.sclk_prev && sy_sclk) begin
        st_next.shift_in = {st_reg.shift_in[6:0], sy_si};
        st_next.bit_cnt  = st_reg.bit_cnt + 3'h1;
        if (st_reg.bit_cnt == `VFD_SER_LAST_BIT) begin
          st_next.shift_out = rd_data;
          st_next.rd_req    = !sy_cmd;
          if (sy_cmd) begin
            st_next.cmd_byte  = {st_reg.shift_in[6:0], sy_si};
            st_next.cmd_valid = 1'b1;
          end else begin
            st_next.data_byte  = {st_reg.shift_in[6:0], sy_si};
            st_next.data_valid = 1'b1;
          end
        end
      end else if (st_reg.sclk_prev && !sy_sclk) begin
        st_next.so        = st_reg.shift_out[7];
        st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
      end
    end else begin
      st_next.bit_cnt   = 3'h0;
      st_next.shift_out = rd_data;
      st_next.so        = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg           <= '0;
      st_reg.wr_prev   <= 1'b1;
      st_reg.rd_prev   <= 1'b1;
      st_reg.sclk_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign host_data_bus_out = st_reg.bus_out;
  assign host_data_bus_oe  = st_reg.bus_oe;
  assign so                = st_reg.so;
  assign frame_pulse       = st_reg.frame_pulse;
  assign cmd_byte          = st_reg.cmd_byte;
  assign cmd_valid         = st_reg.cmd_valid;
  assign data_byte         = st_reg.data_byte;
  assign data_valid        = st_reg.data_valid;
  assign rd_req            = st_reg.rd_req;

  // Checks
  cmd_write_a: assert property (@(posedge clock) disable iff (!rst_b) // see RULE1
    (par_on && !st_reg.wr_prev && sy_wr_b && sy_rd_b && sy_cmd)
      |=> (cmd_valid && !data_valid && cmd_byte == $past(sy_data)))
    else $error("command write not latched");

  data_write_a: assert property (@(posedge clock) disable iff (!rst_b) // see RULE2
    (par_on && !st_reg.wr_prev && sy_wr_b && sy_rd_b && !sy_cmd)
      |=> (data_valid && !cmd_valid && data_byte == $past(sy_data)))
    else $error("data write not latched");

  read_drive_a: assert property (@(posedge clock) disable iff (!rst_b) // see RULE3
    read_cond |=> (host_data_bus_oe && host_data_bus_out == $past(rd_data)))
    else $error("read data not driven");

  cmd_no_drive_a: assert property (@(posedge clock) disable iff (!rst_b) // see RULE5
    (par_on && sy_cmd) |=> !host_data_bus_oe)
    else $error("bus driven during command phase");

  cs_idle_a: assert property (@(posedge clock) disable iff (!rst_b) // see RULE11
    sy_cs_b |=> (!host_data_bus_oe && !cmd_valid && !data_valid && !rd_req))
    else $error("activity while deselected");

  frame_gap_a: assert property (@(posedge clock) disable iff (!rst_b) // see RULE6
    frame_pulse |-> (st_reg.frame_cnt == 16'h0000 && !$past(frame_pulse)))
    else $error("frame pulse out of place");

  strap_mode_a: assert property (@(posedge clock) disable iff (!rst_b) // see RULE7
    $rose(st_reg.strap_done) |-> ((st_reg.mode == vfd_pkg::MODE_SERIAL) == !$past(sy_strap)))
    else $error("port mode does not follow strap");

  serial_quiet_a: assert property (@(posedge clock) disable iff (!rst_b) // see RULE9
    (st_reg.strap_done && st_reg.mode == vfd_pkg::MODE_SERIAL) |-> !host_data_bus_oe)
    else $error("parallel bus driven in serial mode");

  serial_byte_a: assert property (@(posedge clock) disable iff (!rst_b) // see RULE8
    (ser_on && !st_reg.sclk_prev && sy_sclk && st_reg.bit_cnt == 3'h7)
      |=> ((cmd_valid || data_valid) && st_reg.bit_cnt == 3'h0))
    else $error("serial byte not delivered");

endmodule

/* File: vfd_host_model.sv */
// Host model that drives the display port pins.
// Assumes the bench calls its tasks; pins change just after rising edges.
`timescale 1ns/1ps

module vfd_host_model (
  input  logic       clock,
  input  logic [7:0] host_data_bus_out,
  input  logic       host_data_bus_oe,
  input  logic       so,
  output logic       cs_b,
  output logic       wr_b,
  output logic       rd_b,
  output logic       cmd_sel,
  output logic       sclk,
  output logic       si,
  output logic [7:0] host_data_bus_in
);
  logic [7:0] drive;
  logic       host_oe;

  initial begin
    {cs_b, wr_b, rd_b, sclk} = 4'hF;
    {cmd_sel, si, host_oe} = 3'h0;
    drive = 8'h00;
  end

  // Released bus shows the inverse of the last value
  assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : (host_oe ? drive : ~drive);

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic write(input logic sel, input logic en_b, input logic [7:0] b);
    hold(1);
    cs_b    <= en_b;
    cmd_sel <= sel;
    drive   <= b;
    host_oe <= 1'b1;
    hold(4);
    wr_b <= 1'b0;
    hold(5);
    wr_b <= 1'b1;
    hold(2);
    host_oe <= 1'b0;
    cs_b    <= 1'b1;
    hold(5);
  endtask

  task automatic read(input logic sel, input logic en_b, output logic [7:0] b, output logic oe);
    hold(1);
    cs_b    <= en_b;
    cmd_sel <= sel;
    hold(3);
    rd_b <= 1'b0;
    hold(7);
    b  = host_data_bus_in;
    oe = host_data_bus_oe;
    rd_b <= 1'b1;
    hold(1);
    cs_b <= 1'b1;
    hold(6);
  endtask

  task automatic serial(input logic sel, input logic [7:0] b, output logic [7:0] got);
    hold(1);
    cs_b    <= 1'b0;
    cmd_sel <= sel;
    hold(5);
    for (int i = 7; i >= 0; i--) begin
      sclk <= 1'b0;
      si   <= b[i];
      hold(6);
      got[i] = so;
      sclk <= 1'b1;
      hold(5);
    end
    hold(5);
    cs_b <= 1'b1;
    hold(5);
  endtask
endmodule

/* File: tb_top.sv */
// Bench for the display host port with a host model on its pins.
// Assumes the host model and the design files are compiled first.
`timescale 1ns/1ps

module tb_top;
  localparam logic [15:0] FRAMES = 16'h0010;
  logic       clock, rst_b, port_strap, cs_b, wr_b, rd_b, cmd_sel, sclk, si;
  logic       oe, so, frame_pulse, cmd_valid, data_valid, rd_req, oe_seen;
  logic [7:0] rd_data, bus_in, bus_out, cmd_byte, data_byte, b;
  logic       o;
  int         n_errors, comparisons, n_cmd, n_data, n_frame, n_req, c0, d0;

  vfd_host_port #(.FRAME_CYCLES(FRAMES)) i_vfd_host_port (
    .clock(clock), .rst_b(rst_b), .cs_b(cs_b), .wr_b(wr_b), .rd_b(rd_b),
    .cmd_sel(cmd_sel), .port_strap(port_strap), .sclk(sclk), .si(si),
    .host_data_bus_in(bus_in), .rd_data(rd_data), .host_data_bus_out(bus_out),
    .host_data_bus_oe(oe), .so(so), .frame_pulse(frame_pulse), .cmd_byte(cmd_byte),
    .cmd_valid(cmd_valid), .data_byte(data_byte), .data_valid(data_valid), .rd_req(rd_req));

  vfd_host_model i_vfd_host_model (
    .clock(clock), .host_data_bus_out(bus_out), .host_data_bus_oe(oe), .so(so),
    .cs_b(cs_b), .wr_b(wr_b), .rd_b(rd_b), .cmd_sel(cmd_sel), .sclk(sclk), .si(si),
    .host_data_bus_in(bus_in));

  initial begin
    {clock, rst_b, oe_seen} = 3'h0;
    port_strap = 1'b1;
    rd_data    = 8'h00;
  end

  always #20 clock = ~clock;

  // Event counters
  always @(posedge clock) begin
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (data_valid === 1'b1) n_data <= n_data + 1;
    if (frame_pulse === 1'b1) n_frame <= n_frame + 1;
    if (rd_req === 1'b1) n_req <= n_req + 1;
    if (oe === 1'b1) oe_seen <= 1'b1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge clock);
    rst_b      <= 1'b0;
    port_strap <= strap;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (8) @(posedge clock);
  endtask

  task automatic t_write();
    c0 = n_cmd;
    d0 = n_data;
    i_vfd_host_model.write(1'b1, 1'b0, 8'h13);
    check(8'(n_cmd - c0), 8'h01);
    check(cmd_byte, 8'h13);
    i_vfd_host_model.write(1'b0, 1'b0, 8'hA5);
    check(8'(n_data - d0), 8'h01);
    check(data_byte, 8'hA5);
    check(8'(n_cmd - c0), 8'h01);
    $display("write test done");
  endtask

  task automatic t_read();
    c0 = n_req;
    rd_data <= 8'h5A;
    i_vfd_host_model.read(1'b0, 1'b0, b, o);
    check(b, 8'h5A);
    check({7'h00, o}, 8'h01);
    check(8'(n_req - c0), 8'h01);
    oe_seen <= 1'b0;
    i_vfd_host_model.read(1'b1, 1'b0, b, o);
    check({7'h00, oe_seen}, 8'h00);
    $display("read test done");
  endtask

  task automatic t_idle();
    c0 = n_cmd;
    oe_seen <= 1'b0;
    i_vfd_host_model.write(1'b1, 1'b1, 8'h77);
    i_vfd_host_model.read(1'b0, 1'b1, b, o);
    check(8'(n_cmd - c0), 8'h00);
    check({7'h00, oe_seen}, 8'h00);
    $display("idle test done");
  endtask

  task automatic t_frame();
    c0 = n_frame;
    repeat (4 * FRAMES) @(posedge clock);
    check(8'(n_frame - c0), 8'h04);
    $display("frame test done");
  endtask

  task automatic t_serial();
    do_reset(1'b0);
    rd_data <= 8'hC3;
    d0 = n_data;
    i_vfd_host_model.serial(1'b0, 8'h96, b);
    check(data_byte, 8'h96);
    check(b, 8'hC3);
    check(8'(n_data - d0), 8'h01);
    c0 = n_cmd;
    oe_seen <= 1'b0;
    i_vfd_host_model.write(1'b1, 1'b0, 8'h21);
    i_vfd_host_model.read(1'b0, 1'b0, b, o);
    check(8'(n_cmd - c0), 8'h00);
    check({7'h00, oe_seen}, 8'h00);
    i_vfd_host_model.serial(1'b1, 8'h3C, b);
    check(cmd_byte, 8'h3C);
    $display("serial test done");
  endtask

  initial begin
    do_reset(1'b1);
    t_write();
    t_read();
    t_idle();
    t_frame();
    t_serial();
    final_report();
  end

  initial begin
    #(40 * 20000);
    n_errors++;
    final_report();
  end
endmodule
